//--- shared/tmw_pkg.sv
// Constants and types shared by the 16-bit timer waveform control block.
package tmw_pkg;
	localparam int unsigned CNT_W = 16;
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL_A  = 8'h00;
	localparam logic [7:0] OFS_CTRL_B  = 8'h04;
	localparam logic [7:0] OFS_MATCH_A = 8'h08;
	localparam logic [7:0] OFS_MATCH_B = 8'h0C;
	localparam logic [7:0] OFS_CAPT    = 8'h10;
	localparam logic [7:0] OFS_COUNT   = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18;
	localparam logic [7:0] OFS_PORT    = 8'h1C;
	// Field positions.
	localparam int POS_OM_A  = 6;
	localparam int POS_OM_B  = 4;
	localparam int POS_RSV   = 2;
	localparam int POS_WM_LO = 0;
	localparam int POS_WM_HI = 3;
	localparam int ST_OVF    = 0;
	localparam int ST_WAVE_A = 1;
	localparam int ST_WAVE_B = 2;
	localparam int ST_DOWN   = 3;
	localparam int PT_DIR_A  = 0;
	localparam int PT_DIR_B  = 1;
	localparam int PT_DAT_A  = 2;
	localparam int PT_DAT_B  = 3;
	// Reset values.
	localparam logic [7:0]  RST_CTRL = 8'h00;
	localparam logic [1:0]  RST_HI   = 2'h0;
	localparam logic [3:0]  RST_PORT = 4'h0;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [31:0] RD_ZERO  = 32'h00000000;
	// Counter limits.
	localparam logic [15:0] BOTTOM  = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8   = 16'h00FF;
	localparam logic [15:0] TOP_9   = 16'h01FF;
	localparam logic [15:0] TOP_10  = 16'h03FF;
	// Compare-output codes.
	localparam logic [1:0] OM_OFF    = 2'h0;
	localparam logic [1:0] OM_TOGGLE = 2'h1;
	localparam logic [1:0] OM_CLEAR  = 2'h2;
	localparam logic [1:0] OM_SET    = 2'h3;
	// Waveform modes.
	localparam logic [3:0] WM_NORMAL   = 4'h0;
	localparam logic [3:0] WM_PC8      = 4'h1;
	localparam logic [3:0] WM_PC9      = 4'h2;
	localparam logic [3:0] WM_PC10     = 4'h3;
	localparam logic [3:0] WM_CTC_A    = 4'h4;
	localparam logic [3:0] WM_FAST8    = 4'h5;
	localparam logic [3:0] WM_FAST9    = 4'h6;
	localparam logic [3:0] WM_FAST10   = 4'h7;
	localparam logic [3:0] WM_PFC_CAP  = 4'h8;
	localparam logic [3:0] WM_PFC_A    = 4'h9;
	localparam logic [3:0] WM_PC_CAP   = 4'hA;
	localparam logic [3:0] WM_PC_A     = 4'hB;
	localparam logic [3:0] WM_CTC_CAP  = 4'hC;
	localparam logic [3:0] WM_RSVD     = 4'hD;
	localparam logic [3:0] WM_FAST_CAP = 4'hE;
	localparam logic [3:0] WM_FAST_A   = 4'hF;
	typedef enum logic [1:0] {CLS_SINGLE, CLS_FAST, CLS_DUAL} tmw_cls_t;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} tmw_apb_req_t;
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} tmw_apb_rsp_t;
	typedef struct packed {
		logic o;
		logic oe;
	} tmw_pin_t;
endpackage

//--- rtl/tmw_top.sv
// Timer waveform mode decode, counter, compare-output control, APB slave.
//
// Notes on behaviour
// RQ1 - Nonzero channel A code takes pin A; code 01 in PWM modes other than 8-11 and 14/15 leaves it on port data.
// RQ2 - Nonzero channel B code takes pin B; code 01 in any PWM mode leaves it on port data.
// RQ3 - Pin driven only when direction bit selects output.
// RQ4 - Code 00 leaves pin on port data.
// RQ5 - Non-PWM: 01 toggle, 10 clear, 11 set.
// RQ6 - Fast PWM toggle only channel A, modes 14/15.
// RQ7 - Fast PWM: 10 clear-match/set-top, 11 opposite.
// RQ8 - Fast PWM: match at TOP ignored, TOP acts.
// RQ9 - Dual-slope toggle only channel A, modes 8-11.
// RQ10 - Dual-slope: 10 clear up, set down.
// RQ11 - Mode joins control B high, A low bits.
// RQ12 - TOP chosen per waveform mode.
// RQ13 - Phase correct: load at TOP, flag BOTTOM.
// RQ14 - Phase/frequency correct: load and flag BOTTOM.
// RQ15 - Fast PWM: load and flag at TOP.
// RQ16 - Normal/CLEAR_ON_MATCH_MODE: immediate compare, flag at MAX.
// RQ17 - Software avoids reserved mode 13.
// RQ18 - Control A bits 3:2 read zero.
// RQ19 - Upper mode bits sit at control B 4:3.
// RQ20 - Dual-slope extremes hold output steady.
`timescale 1ns/1ps
`default_nettype none
module tmw_top
	import tmw_pkg::*;
(
	// Clock and reset
	input  wire logic         CLK,
	input  wire logic         SRST,
	// Timer clock enable
	input  wire logic         TICK,
	// APB slave
	input  wire tmw_apb_req_t APB_REQ,
	output var  tmw_apb_rsp_t APB_RSP,
	// Waveform pins and overflow level
	output var  tmw_pin_t     WAVE_PIN_A,
	output var  tmw_pin_t     WAVE_PIN_B,
	output var  logic         OVERFLOW_FLAG
);

	function automatic tmw_cls_t cls_of(input logic [3:0] m);
		unique case (m)
			WM_PC8, WM_PC9, WM_PC10, WM_PFC_CAP, WM_PFC_A,
			WM_PC_CAP, WM_PC_A:
				cls_of = CLS_DUAL;
			WM_FAST8, WM_FAST9, WM_FAST10, WM_FAST_CAP,
			WM_FAST_A:
				cls_of = CLS_FAST;
			default:
				cls_of = CLS_SINGLE;
		endcase
	endfunction

	function automatic logic [15:0] top_of(input logic [3:0] m,
		input logic [15:0] oa, input logic [15:0] ic);
		unique case (m)
			WM_PC8, WM_FAST8:
				top_of = TOP_8;
			WM_PC9, WM_FAST9:
				top_of = TOP_9;
			WM_PC10, WM_FAST10:
				top_of = TOP_10;
			WM_CTC_A, WM_PFC_A, WM_PC_A, WM_FAST_A:
				top_of = oa;
			WM_PFC_CAP, WM_PC_CAP, WM_CTC_CAP, WM_FAST_CAP:
				top_of = ic;
			default:
				top_of = TOP_MAX;
		endcase
	endfunction

	// A PWM toggle code without toggle support leaves the pin alone.
	function automatic logic conn_of(input logic [1:0] om,
		input tmw_cls_t c, input logic tog_ok);
		conn_of = (om != OM_OFF) &&
			!(c != CLS_SINGLE && om == OM_TOGGLE && !tog_ok);
	endfunction

	function automatic logic wave_of(input logic [1:0] om,
		input logic cur, input tmw_cls_t c, input logic tog_ok,
		input logic hit, input logic at_top, input logic up,
		input logic [15:0] ocr, input logic [15:0] top);
		logic v;
		v = cur;
		unique case (c)
			CLS_SINGLE:
			begin
				if (hit && om == OM_TOGGLE)
					v = ~cur; // [RQ5]
				else if (hit && om[1])
					v = om[0]; // [RQ5]
			end
			CLS_FAST:
			begin
				if (om[1])
				begin
					if (hit && ocr != top)
						v = om[0]; // [RQ7] [RQ8]
					if (at_top)
						v = ~om[0]; // [RQ7] [RQ8]
				end
				else if (om == OM_TOGGLE && tog_ok && hit)
					v = ~cur; // [RQ6]
			end
			CLS_DUAL:
			begin
				if (om[1])
				begin
					if (ocr == BOTTOM)
						v = om[0]; // [RQ20]
					else if (ocr == top)
						v = ~om[0]; // [RQ20]
					else if (hit)
						v = up ? om[0] : ~om[0]; // [RQ10]
				end
				else if (om == OM_TOGGLE && tog_ok && hit)
					v = ~cur; // [RQ9]
			end
		endcase
		wave_of = v;
	endfunction

	// Register file state.
	logic [7:0]   ctrl_a_reg, ctrl_a_next;
	logic [1:0]   wm_hi_reg, wm_hi_next;
	logic [15:0]  buf_a_reg, buf_a_next;
	logic [15:0]  buf_b_reg, buf_b_next;
	logic [15:0]  capt_reg, capt_next;
	logic [3:0]   port_reg, port_next;
	tmw_apb_rsp_t rsp_next;
	logic         acc, wr;

	// Timer state.
	logic [15:0]  cnt_reg, cnt_next;
	logic         up_reg, up_next;
	logic [15:0]  act_a_reg, act_a_next;
	logic [15:0]  act_b_reg, act_b_next;
	logic         wave_a_reg, wave_a_next;
	logic         wave_b_reg, wave_b_next;
	logic         ovf_reg, ovf_next;
	tmw_pin_t     pin_a_next, pin_b_next;

	logic [3:0]   mode;
	tmw_cls_t     cls;
	logic [15:0]  top;
	logic [1:0]   om_a, om_b;
	logic         at_top, at_bot, hit_a, hit_b;
	logic         tog_ok_a, conn_a, conn_b, pfc, load, ovf_ev;

	assign om_a = ctrl_a_reg[POS_OM_A +: 2];
	assign om_b = ctrl_a_reg[POS_OM_B +: 2];
	assign mode = {wm_hi_reg, ctrl_a_reg[POS_WM_LO +: 2]}; // [RQ11]
	assign cls  = cls_of(mode);
	assign top  = top_of(mode, act_a_reg, capt_reg); // [RQ12]
	assign at_top = cnt_reg == top;
	assign at_bot = cnt_reg == BOTTOM;
	assign hit_a  = TICK && cnt_reg == act_a_reg;
	assign hit_b  = TICK && cnt_reg == act_b_reg;
	assign tog_ok_a = (cls == CLS_FAST) ?
		(mode == WM_FAST_CAP || mode == WM_FAST_A) : // [RQ6]
		(mode == WM_PFC_CAP || mode == WM_PFC_A ||
		 mode == WM_PC_CAP || mode == WM_PC_A); // [RQ9]
	assign conn_a = conn_of(om_a, cls, tog_ok_a); // [RQ1] [RQ4]
	// Channel B never toggles in PWM modes.
	assign conn_b = conn_of(om_b, cls, 1'b0); // [RQ2] [RQ6] [RQ9]
	assign pfc    = mode == WM_PFC_CAP || mode == WM_PFC_A;
	assign load   = TICK && (pfc ? at_bot : at_top); // [RQ13] [RQ14] [RQ15]

	// APB: one wait state, answer registered.
	assign acc = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready;
	assign wr  = acc && APB_REQ.pwrite;

	always_comb
	begin
		ctrl_a_next = ctrl_a_reg;
		wm_hi_next  = wm_hi_reg;
		buf_a_next  = buf_a_reg;
		buf_b_next  = buf_b_reg;
		capt_next   = capt_reg;
		port_next   = port_reg;
		rsp_next.pready  = APB_REQ.psel && APB_REQ.penable &&
			!APB_RSP.pready;
		rsp_next.pslverr = 1'b0;
		rsp_next.prdata  = RD_ZERO;
		if (wr)
		begin
			unique case (APB_REQ.paddr)
				OFS_CTRL_A:
				begin
					ctrl_a_next = APB_REQ.pwdata[7:0];
					ctrl_a_next[POS_RSV +: 2] = OM_OFF; // [RQ18]
				end
				OFS_CTRL_B:
					wm_hi_next = APB_REQ.pwdata[POS_WM_HI +: 2]; // [RQ19]
				OFS_MATCH_A:
					buf_a_next = APB_REQ.pwdata[15:0];
				OFS_MATCH_B:
					buf_b_next = APB_REQ.pwdata[15:0];
				OFS_CAPT:
					capt_next = APB_REQ.pwdata[15:0];
				OFS_PORT:
					port_next = APB_REQ.pwdata[3:0];
				default:
				begin
				end
			endcase
		end
		if (rsp_next.pready)
		begin
			unique case (APB_REQ.paddr)
				OFS_CTRL_A:
					rsp_next.prdata[7:0] = ctrl_a_reg; // [RQ18]
				OFS_CTRL_B:
					rsp_next.prdata[POS_WM_HI +: 2] = wm_hi_reg;
				OFS_MATCH_A:
					rsp_next.prdata[15:0] = buf_a_reg;
				OFS_MATCH_B:
					rsp_next.prdata[15:0] = buf_b_reg;
				OFS_CAPT:
					rsp_next.prdata[15:0] = capt_reg;
				OFS_COUNT:
					rsp_next.prdata[15:0] = cnt_reg;
				OFS_STATUS:
					rsp_next.prdata[3:0] = {~up_reg, wave_b_reg,
						wave_a_reg, ovf_reg};
				OFS_PORT:
					rsp_next.prdata[3:0] = port_reg;
				default:
					rsp_next.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			ctrl_a_reg <= RST_CTRL;
			wm_hi_reg  <= RST_HI;
			buf_a_reg  <= RST_WORD;
			buf_b_reg  <= RST_WORD;
			capt_reg   <= RST_WORD;
			port_reg   <= RST_PORT;
			APB_RSP    <= '0;
		end
		else
		begin
			ctrl_a_reg <= ctrl_a_next;
			wm_hi_reg  <= wm_hi_next;
			buf_a_reg  <= buf_a_next;
			buf_b_reg  <= buf_b_next;
			capt_reg   <= capt_next;
			port_reg   <= port_next;
			APB_RSP    <= rsp_next;
		end
	end

	// Counter, compare buffers, overflow flag and waveform outputs.
	always_comb
	begin
		cnt_next = cnt_reg;
		up_next  = up_reg;
		ovf_ev   = 1'b0;
		if (TICK)
		begin
			if (cls == CLS_DUAL)
			begin
				ovf_ev = at_bot && !up_reg; // [RQ13] [RQ14]
				if (up_reg && at_top)
				begin
					up_next  = 1'b0;
					cnt_next = cnt_reg - CNT_ONE;
				end
				else if (!up_reg && at_bot)
				begin
					up_next  = 1'b1;
					cnt_next = cnt_reg + CNT_ONE;
				end
				else
					cnt_next = up_reg ? cnt_reg + CNT_ONE :
						cnt_reg - CNT_ONE;
			end
			else
			begin
				up_next  = 1'b1;
				cnt_next = at_top ? BOTTOM : cnt_reg + CNT_ONE;
				ovf_ev   = (cls == CLS_FAST) ? at_top : // [RQ15]
					cnt_reg == TOP_MAX; // [RQ16]
			end
		end
		// Unbuffered modes track software writes in the same cycle.
		act_a_next = (cls == CLS_SINGLE) ? buf_a_next : // [RQ16]
			(load ? buf_a_reg : act_a_reg);
		act_b_next = (cls == CLS_SINGLE) ? buf_b_next :
			(load ? buf_b_reg : act_b_reg);
		// A new event beats a write-one clear in the same cycle.
		ovf_next = ovf_ev || (ovf_reg && !(wr &&
			APB_REQ.paddr == OFS_STATUS && APB_REQ.pwdata[ST_OVF]));
		wave_a_next = wave_of(om_a, wave_a_reg, cls, tog_ok_a, hit_a,
			TICK && at_top, up_reg, act_a_reg, top);
		wave_b_next = wave_of(om_b, wave_b_reg, cls, 1'b0, hit_b,
			TICK && at_top, up_reg, act_b_reg, top);
		pin_a_next.o  = conn_a ? wave_a_next : port_next[PT_DAT_A];
		pin_a_next.oe = port_next[PT_DIR_A]; // [RQ3]
		pin_b_next.o  = conn_b ? wave_b_next : port_next[PT_DAT_B];
		pin_b_next.oe = port_next[PT_DIR_B]; // [RQ3]
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			cnt_reg       <= RST_WORD;
			up_reg        <= 1'b1;
			act_a_reg     <= RST_WORD;
			act_b_reg     <= RST_WORD;
			ovf_reg       <= 1'b0;
			wave_a_reg    <= 1'b0;
			wave_b_reg    <= 1'b0;
			WAVE_PIN_A    <= '0;
			WAVE_PIN_B    <= '0;
			OVERFLOW_FLAG <= 1'b0;
		end
		else
		begin
			cnt_reg       <= cnt_next;
			up_reg        <= up_next;
			act_a_reg     <= act_a_next;
			act_b_reg     <= act_b_next;
			ovf_reg       <= ovf_next;
			wave_a_reg    <= wave_a_next;
			wave_b_reg    <= wave_b_next;
			WAVE_PIN_A    <= pin_a_next;
			WAVE_PIN_B    <= pin_b_next;
			OVERFLOW_FLAG <= ovf_next;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	sequence s_wait;
		APB_REQ.psel && APB_REQ.penable && !APB_RSP.pready;
	endsequence
	sequence s_fast_top;
		cls == CLS_FAST && TICK && at_top;
	endsequence

	a_apb_one_wait: assert property (s_wait |=> APB_RSP.pready) // APB one wait state
		else $error("APB answer not one cycle after access");
	a_rsv_read_zero: assert property (APB_RSP.pready && // [RQ18]
		APB_REQ.paddr == OFS_CTRL_A |-> APB_RSP.prdata[3:2] == 2'h0)
		else $error("reserved control bits read nonzero");
	a_pin_dir_gate: assert property (WAVE_PIN_B.oe == // [RQ3]
		port_reg[PT_DIR_B])
		else $error("pin B enable does not follow direction");
	a_off_port_data: assert property ($past(om_a) == OM_OFF |-> // [RQ4]
		WAVE_PIN_A.o == port_reg[PT_DAT_A])
		else $error("code 00 did not give port data");
	a_nonpwm_set: assert property (cls == CLS_SINGLE && // [RQ5]
		om_a == OM_SET && hit_a |=> wave_a_reg && WAVE_PIN_A.o)
		else $error("non-PWM set on match failed");
	a_fast_b_toggle: assert property (cls == CLS_FAST && // [RQ6]
		om_b == OM_TOGGLE |=> WAVE_PIN_B.o == port_reg[PT_DAT_B])
		else $error("fast PWM toggle reached pin B");
	a_fast_top_set: assert property (s_fast_top and // [RQ7]
		(om_a == OM_CLEAR) |=> wave_a_reg)
		else $error("fast PWM did not set at TOP");
	a_dual_up_clear: assert property (cls == CLS_DUAL && // [RQ10]
		om_a == OM_CLEAR && hit_a && up_reg && act_a_reg != BOTTOM &&
		act_a_reg != top |=> !wave_a_reg)
		else $error("dual-slope up match did not clear");
	a_fast_ovf_top: assert property (s_fast_top |=> // [RQ15]
		OVERFLOW_FLAG ##1 OVERFLOW_FLAG || $past(wr))
		else $error("fast PWM overflow not set at TOP");
	a_dual_ovf_bot: assert property (cls == CLS_DUAL && TICK && // [RQ13]
		at_bot && !up_reg |=> ovf_reg)
		else $error("dual-slope overflow not set at BOTTOM");
	a_imm_write: assert property (cls == CLS_SINGLE && wr && // [RQ16]
		APB_REQ.paddr == OFS_MATCH_A && $stable(mode) |=>
		act_a_reg == $past(APB_REQ.pwdata[15:0]))
		else $error("immediate compare write not applied");
	a_top_fixed: assert property (mode == WM_FAST9 |-> // [RQ12]
		top == TOP_9)
		else $error("9-bit TOP wrong");

endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking testbench for the timer waveform control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tmw_pkg::*;
	logic         clk;
	logic         srst;
	logic         tick;
	tmw_apb_req_t req;
	tmw_apb_rsp_t rsp;
	tmw_pin_t     pa;
	tmw_pin_t     pb;
	logic         ovf;
	logic [31:0]  rd;
	logic         er;
	int           bad_count;
	int           n_compared;
	int           tr_a;
	int           tr_b;
	int           hi_a;
	int           same_ab;
	int           n;
	logic [3:0]   tm [8] = '{WM_FAST_A, WM_FAST_CAP, WM_PC_A, WM_PFC_A,
		WM_PFC_CAP, WM_PC_CAP, WM_FAST8, WM_PC8};
	int           tx [8] = '{14, 14, 8, 8, 8, 8, 0, 0};
	logic [3:0]   pm [9] = '{WM_FAST8, WM_FAST_CAP, WM_PC8, WM_PFC_CAP,
		WM_PC_CAP, WM_FAST9, WM_PC9, WM_FAST10, WM_PC10};
	int           pp [9] = '{256, 256, 510, 510, 510, 512, 1022, 1024, 2046};

	tmw_top dut
	(
		.CLK           (clk),
		.SRST          (srst),
		.TICK          (tick),
		.APB_REQ       (req),
		.APB_RSP       (rsp),
		.WAVE_PIN_A    (pa),
		.WAVE_PIN_B    (pb),
		.OVERFLOW_FLAG (ovf)
	);

	initial
		clk = 1'b0;
	always
		#2 clk = ~clk;

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got,
				exp);
		end
	endtask

	// One transfer; the wait for pready is bounded so a dead slave shows.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int k;
		@(posedge clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= wd;
		@(posedge clk);
		req.penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (rsp.pready !== 1'b1 && k < 20);
		chk(k < 20, 1'b1, "no pready");
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	// Ticks stop near BOTTOM while the mode changes, so the frozen count
	// never lies above the new TOP and the counter cannot run to 0xFFFF.
	task automatic set_mode(input logic [3:0] m, input logic [1:0] ca,
		input logic [1:0] cb);
		int k;
		k = 0;
		do
		begin
			apb(1'b0, OFS_COUNT, RD_ZERO);
			k++;
		end
		while (rd > 32'h3 && k < 1000);
		tick <= 1'b0;
		// Low mode bits go to zero first, so no step passes through 13.
		apb(1'b1, OFS_CTRL_A, {24'h000000, ca, cb, 4'h0});
		apb(1'b1, OFS_CTRL_B, {27'h0000000, m[3:2], 3'h0});
		apb(1'b1, OFS_CTRL_A, {24'h000000, ca, cb, 2'h0, m[1:0]});
		tick <= 1'b1;
	endtask

	task automatic watch(input int cyc);
		tmw_pin_t la;
		tmw_pin_t lb;
		tr_a = 0;
		tr_b = 0;
		hi_a = 0;
		same_ab = 0;
		la = pa;
		lb = pb;
		repeat (cyc)
		begin
			@(posedge clk);
			tr_a += int'(pa.o !== la.o);
			tr_b += int'(pb.o !== lb.o);
			hi_a += int'(pa.o === 1'b1);
			same_ab += int'(pa.o === pb.o);
			la = pa;
			lb = pb;
		end
	endtask

	// Counts cycles until pin A next moves to level v.
	task automatic wait_a(input logic v);
		logic l;
		n = 0;
		do
		begin
			l = pa.o;
			@(posedge clk);
			n++;
		end
		while (!(l !== v && pa.o === v) && n < 5000);
		chk(n < 5000, 1'b1, "pin a stuck");
	endtask

	initial
	begin
		repeat (90000) @(posedge clk);
		bad_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		end_sim();
	end

	initial
	begin
		bad_count = 0;
		n_compared = 0;
		req = '0;
		tick = 1'b0;
		srst = 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		apb(1'b0, OFS_CTRL_A, 32'h0);
		chk(rd, 32'h0, "ctrl a reset");
		chk(pa.oe, 1'b0, "pin a reset");
		apb(1'b1, OFS_CTRL_A, 32'hFF);
		apb(1'b0, OFS_CTRL_A, 32'h0);
		chk(rd, 32'hF3, "ctrl a read");
		apb(1'b1, OFS_CTRL_B, 32'h18);
		apb(1'b0, OFS_CTRL_B, 32'h0);
		chk(rd, 32'h18, "ctrl b read");
		apb(1'b0, 8'h40, 32'h0);
		chk(er, 1'b1, "unmapped");
		$display("test registers done");
		// The counter is held until the CLEAR_ON_MATCH_MODE top is set, so it never wraps.
		apb(1'b1, OFS_MATCH_A, 32'h3);
		set_mode(WM_CTC_A, OM_SET, OM_SET);
		watch(20);
		chk(pa.oe, 1'b0, "a driven as input");
		chk(pb.oe, 1'b0, "b driven as input");
		apb(1'b1, OFS_PORT, 32'h3);
		watch(8);
		chk(pa.oe, 1'b1, "a not taken");
		chk(pb.oe, 1'b1, "b not taken");
		chk(pa.o, 1'b1, "a set");
		set_mode(WM_CTC_A, OM_CLEAR, OM_TOGGLE);
		watch(8);
		chk(pa.o, 1'b0, "a clear");
		watch(40);
		chk(tr_b, 32'hA, "b toggles");
		chk(ovf, 1'b0, "ctc overflow");
		apb(1'b1, OFS_PORT, 32'h7);
		set_mode(WM_CTC_A, OM_OFF, OM_OFF);
		watch(20);
		chk(pa.o, 1'b1, "a port data");
		chk(tr_a, 32'h0, "a disconnected");
		$display("test non-pwm done");
		apb(1'b1, OFS_MATCH_A, 32'h7);
		apb(1'b1, OFS_CAPT, 32'h7);
		for (int i = 0; i < 8; i++)
		begin
			set_mode(tm[i], OM_TOGGLE, OM_TOGGLE);
			watch(30);
			watch(112);
			chk(tr_a, tx[i], "a toggle count");
			chk(tr_b, 32'h0, "b toggle");
		end
		$display("test toggle done");
		apb(1'b1, OFS_MATCH_A, 32'h40);
		apb(1'b1, OFS_MATCH_B, 32'h40);
		apb(1'b1, OFS_CAPT, 32'hFF);
		for (int i = 0; i < 9; i++)
		begin
			set_mode(pm[i], OM_CLEAR, OM_SET);
			wait_a(1'b1);
			wait_a(1'b1);
			wait_a(1'b1);
			chk(n, pp[i], "period");
			watch(pp[i]);
			chk(same_ab, 32'h0, "a b not inverse");
			wait_a(1'b0);
			apb(1'b1, OFS_STATUS, 32'h1);
			@(posedge clk);
			n = 0;
			while (ovf !== 1'b1 && n < 5000)
			begin
				@(posedge clk);
				n++;
			end
			wait_a(1'b0);
			chk(n >= 62 && n <= 67, 1'b1, "flag");
		end
		$display("test pwm done");
		apb(1'b1, OFS_MATCH_A, 32'h0);
		apb(1'b1, OFS_MATCH_B, 32'h3FF);
		watch(2100);
		watch(2100);
		chk(hi_a, 32'h0, "bottom level");
		chk(same_ab, 32'd2100, "top level");
		apb(1'b1, OFS_MATCH_A, 32'h3FF);
		set_mode(WM_FAST10, OM_CLEAR, OM_SET);
		watch(1100);
		watch(1100);
		chk(hi_a, 32'd1100, "match at top");
		chk(same_ab, 32'h0, "top only");
		$display("test extremes done");
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		apb(1'b0, OFS_CTRL_A, 32'h0);
		chk(rd, 32'h0, "ctrl a rereset");
		chk(pa.oe, 1'b0, "pin a rereset");
		$display("test second reset done");
		end_sim();
	end
endmodule
`default_nettype wire
